// File: hw/sclid_pkg.sv
// Shared constants for the scanner control input decoder: control word layout,
// pulse timing, controller register map and the device safety states.
// Assumes a single 20 MHz system clock on both ends.
package sclid_pkg;

	// ==========================================================================
	// Clock and pulse timing
	// ==========================================================================
	localparam int CLK_HZ = 20_000_000;
	localparam int FIELD_MIN_MS = 60;
	localparam int CMD_MIN_MS = 120;
	// Least times round down; both divide exactly at this rate
	localparam int FIELD_MIN_CYC = (FIELD_MIN_MS * (CLK_HZ / 1000));
	localparam int CMD_MIN_CYC = (CMD_MIN_MS * (CLK_HZ / 1000));
	localparam int CNT_W = 22;

	// ==========================================================================
	// Control word layout
	// ==========================================================================
	localparam int NUM_PATHS = 4;
	localparam int NUM_SEL = 8;
	localparam int NUM_CH = 7;
	localparam int CH_RUN = 4;
	localparam int CH_SOFT = 5;
	localparam int CH_FULL = 6;
	localparam int CASE_W = 5;
	localparam logic [4:0] CASE_NONE = 5'h00;
	localparam logic [7:0] HIST_MAX = 8'hff;
	localparam logic [3:0] WAIT_RST = 4'hf;

	// ==========================================================================
	// Controller register map (APB, one word each)
	// ==========================================================================
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_SEL = 12'h004;
	localparam logic [11:0] REG_PULSE = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;
	localparam int CTRL_CASE_EN_BIT = 0;
	localparam int CTRL_SLEEP_BIT = 1;
	localparam int CTRL_FREEZE_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [7:0] SEL_RST = 8'h00;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_APP_BIT = 1;
	localparam int STAT_WAIT_LSB = 2;
	localparam int STAT_SLEEP_BIT = 6;

	// ==========================================================================
	// Device safety states
	// ==========================================================================
	typedef enum logic [3:0] {
		SAFE_RUN = 4'h1,
		SAFE_APP_FAULT = 4'h2,
		SAFE_DEV_FAULT = 4'h4,
		SAFE_RESTART = 4'h8
	} sclid_safe_type;

endpackage

// File: hw/sclid_ctrl_if.sv
// Cyclic control word from controller to device, and the status bits back.
// Both ends run on the same system clock; no clocking block.
`timescale 1ns/1ps
interface sclid_ctrl_if;
	logic case_switch_enable;
	logic sleep_request;
	logic [7:0] case_selector;
	logic event_history_freeze;
	logic [3:0] path_interlock_clear;
	logic safety_function_restart;
	logic soft_restart_request;
	logic full_restart_request;
	logic safety_running_flag;
	logic application_error_flag;
	logic [3:0] path_waiting_clear_flag;
	logic sleep_active_flag;

	modport device (
		input case_switch_enable, sleep_request, case_selector, event_history_freeze,
		input path_interlock_clear, safety_function_restart, soft_restart_request,
		input full_restart_request,
		output safety_running_flag, application_error_flag, path_waiting_clear_flag,
		output sleep_active_flag
	);

	modport controller (
		output case_switch_enable, sleep_request, case_selector, event_history_freeze,
		output path_interlock_clear, safety_function_restart, soft_restart_request,
		output full_restart_request,
		input safety_running_flag, application_error_flag, path_waiting_clear_flag,
		input sleep_active_flag
	);
endinterface

// File: hw/sclid_device.sv
// Device end: samples the control word, times command pulses, switches the
// monitoring case, keeps the path interlocks, event history and safety state.
// Assumes the control word is synchronous to sys_clk.
`timescale 1ns/1ps
module sclid_device #(
	parameter int FIELD_MIN_CYC = sclid_pkg::FIELD_MIN_CYC,
	parameter int CMD_MIN_CYC = sclid_pkg::CMD_MIN_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control word from the controller
	sclid_ctrl_if.device ctl,
	// Configuration and device events
	input wire logic pair_mode,
	input wire logic app_error_event,
	input wire logic dev_error_event,
	input wire logic [3:0] field_interrupt,
	// Monitoring case
	output logic [4:0] active_case,
	output logic case_reject,
	// Event history
	output logic [7:0] history_count,
	output logic history_write,
	// Restart outputs
	output logic device_restart,
	output logic net_stack_restart,
	output logic switch_forward_off
);

	localparam int W = sclid_pkg::CNT_W;

	// ==========================================================================
	// Decoding helpers
	// ==========================================================================

	// Returns {valid, case code}; code 0 is reserved for no active case
	function automatic logic [5:0] decode_case(input logic [7:0] sel, input logic pairs);
		logic [5:0] res;
		logic [3:0] pat;
		int hits;
		res = 6'h00;
		pat = 4'h0;
		hits = 0;
		if (pairs) begin
			res[5] = 1'b1;
			for (int k = 0; k < 4; k++) begin
				pat[k] = sel[2 * k];
				if (sel[2 * k] == sel[2 * k + 1]) begin
					res[5] = 1'b0;
				end
			end
			res[4:0] = 5'({1'b0, pat} + 5'h01);
		end else begin
			for (int k = 0; k < 8; k++) begin
				if (sel[k]) begin
					hits = hits + 1;
					res[4:0] = 5'(k + 1);
				end
			end
			res[5] = (hits == 1);
		end
		return res;
	endfunction

	// Number of paths interrupted in one cycle
	function automatic logic [2:0] count_hits(input logic [3:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int k = 0; k < 4; k++) begin
			n = n + 3'(v[k]);
		end
		return n;
	endfunction

	// ==========================================================================
	// Pulse qualification, one channel per pulse bit
	// ==========================================================================
	logic [6:0] ch_level;
	logic [6:0] ch_fire;

	assign ch_level = {ctl.full_restart_request, ctl.soft_restart_request,
		ctl.safety_function_restart, ctl.path_interlock_clear};

	genvar gi;
	generate
		for (gi = 0; gi < sclid_pkg::NUM_CH; gi++) begin : g_ch
			localparam logic [W-1:0] MIN_C = (gi < sclid_pkg::NUM_PATHS) ?
				W'(FIELD_MIN_CYC) : W'(CMD_MIN_CYC);
			logic [W-1:0] cnt_r;
			logic armed_r;

			// A bit already high at reset is a held level, never a pulse
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					armed_r <= 1'b0;
				end else if (!ch_level[gi]) begin
					armed_r <= 1'b1;
				end
			end

			// High-phase length, saturating at the minimum
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					cnt_r <= '0;
				end else if (ch_level[gi] && armed_r) begin
					cnt_r <= (cnt_r == MIN_C) ? cnt_r : cnt_r + 1'b1;
				end else begin
					cnt_r <= '0;
				end
			end

			if (gi < sclid_pkg::NUM_PATHS) begin : g_field
				// Fires once per rising edge, when its high phase is long enough
				assign ch_fire[gi] = ch_level[gi] && armed_r && (cnt_r == MIN_C - 1'b1);
			end else begin : g_cmd
				// Fires at the falling edge of a long enough pulse only
				assign ch_fire[gi] = !ch_level[gi] && (cnt_r == MIN_C);
			end
		end
	endgenerate

	// ==========================================================================
	// Safety state
	// ==========================================================================
	sclid_pkg::sclid_safe_type state_r;
	sclid_pkg::sclid_safe_type state_nxt;
	logic restart_go;

	assign restart_go = ch_fire[sclid_pkg::CH_SOFT] || ch_fire[sclid_pkg::CH_FULL];

	// Device errors outrank application errors; a run start leaves only an application error, a soft or full restart leaves both
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			sclid_pkg::SAFE_RUN: begin
				if (dev_error_event) begin
					state_nxt = sclid_pkg::SAFE_DEV_FAULT;
				end else if (app_error_event) begin
					state_nxt = sclid_pkg::SAFE_APP_FAULT;
				end
			end
			sclid_pkg::SAFE_APP_FAULT: begin
				if (restart_go) begin
					state_nxt = sclid_pkg::SAFE_RESTART;
				end else if (dev_error_event) begin
					state_nxt = sclid_pkg::SAFE_DEV_FAULT;
				end else if (ch_fire[sclid_pkg::CH_RUN]) begin
					state_nxt = sclid_pkg::SAFE_RUN;
				end
			end
			sclid_pkg::SAFE_DEV_FAULT: begin
				if (restart_go) begin
					state_nxt = sclid_pkg::SAFE_RESTART;
				end
			end
			sclid_pkg::SAFE_RESTART: begin
				state_nxt = sclid_pkg::SAFE_RUN;
			end
			default: begin
				state_nxt = sclid_pkg::SAFE_RESTART;
			end
		endcase
		if (restart_go && state_r == sclid_pkg::SAFE_RUN) begin
			state_nxt = sclid_pkg::SAFE_RESTART;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= sclid_pkg::SAFE_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Restart strobes; a full restart also takes the stack and switch down
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			device_restart <= 1'b0;
			net_stack_restart <= 1'b0;
			switch_forward_off <= 1'b0;
		end else begin
			device_restart <= restart_go;
			net_stack_restart <= ch_fire[sclid_pkg::CH_FULL];
			switch_forward_off <= ch_fire[sclid_pkg::CH_FULL];
		end
	end

	// Status flags back to the controller
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctl.safety_running_flag <= 1'b0;
			ctl.application_error_flag <= 1'b0;
			ctl.sleep_active_flag <= 1'b0;
		end else begin
			ctl.safety_running_flag <= (state_nxt == sclid_pkg::SAFE_RUN);
			ctl.application_error_flag <= (state_nxt == sclid_pkg::SAFE_APP_FAULT);
			ctl.sleep_active_flag <= ctl.sleep_request;
		end
	end

	// ==========================================================================
	// Path interlocks
	// ==========================================================================

	// An interruption in the same cycle as a clear wins: the path stays locked
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctl.path_waiting_clear_flag <= sclid_pkg::WAIT_RST;
		end else if (restart_go) begin
			ctl.path_waiting_clear_flag <= sclid_pkg::WAIT_RST;
		end else begin
			ctl.path_waiting_clear_flag <= field_interrupt |
				(ctl.path_waiting_clear_flag & ~ch_fire[3:0]);
		end
	end

	// ==========================================================================
	// Event history
	// ==========================================================================
	logic [8:0] hist_sum;

	assign hist_sum = {1'b0, history_count} + {6'h00, count_hits(field_interrupt)};

	// Saturates rather than wraps so old totals are never lost
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			history_count <= 8'h00;
			history_write <= 1'b0;
		end else if (!ctl.event_history_freeze && (|field_interrupt)) begin
			history_count <= hist_sum[8] ? sclid_pkg::HIST_MAX : hist_sum[7:0];
			history_write <= 1'b1;
		end else begin
			history_write <= 1'b0;
		end
	end

	// ==========================================================================
	// Monitoring case switching
	// ==========================================================================
	logic [5:0] case_dec;

	assign case_dec = decode_case(ctl.case_selector, pair_mode);

	// With switching disabled the current case is simply held
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			active_case <= sclid_pkg::CASE_NONE;
			case_reject <= 1'b0;
		end else if (ctl.case_switch_enable && case_dec[5]) begin
			active_case <= case_dec[4:0];
			case_reject <= 1'b0;
		end else begin
			case_reject <= ctl.case_switch_enable;
		end
	end

endmodule

// File: hw/sclid_controller.sv
// Controller end: an APB slave whose registers set the control word levels and
// launch timed command pulses, and which reads back the device status bits.
// Assumes APB master and device share sys_clk.
`timescale 1ns/1ps
module sclid_controller #(
	parameter int FIELD_MIN_CYC = sclid_pkg::FIELD_MIN_CYC,
	parameter int CMD_MIN_CYC = sclid_pkg::CMD_MIN_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Control word to the device
	sclid_ctrl_if.controller ctl
);

	localparam int W = sclid_pkg::CNT_W;

	// ==========================================================================
	// Bus decode
	// ==========================================================================
	logic setup;
	logic wr;
	logic [6:0] busy;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	// No wait states: data is prepared in the setup cycle
	assign pready = 1'b1;

	// Read data and error are captured in the setup cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			unique case (paddr)
				sclid_pkg::REG_CTRL: begin
					prdata[2:0] <= {ctl.event_history_freeze, ctl.sleep_request,
						ctl.case_switch_enable};
				end
				sclid_pkg::REG_SEL: begin
					prdata[7:0] <= ctl.case_selector;
				end
				sclid_pkg::REG_PULSE: begin
					prdata[6:0] <= busy;
				end
				sclid_pkg::REG_STATUS: begin
					prdata[sclid_pkg::STAT_RUN_BIT] <= ctl.safety_running_flag;
					prdata[sclid_pkg::STAT_APP_BIT] <= ctl.application_error_flag;
					prdata[sclid_pkg::STAT_WAIT_LSB +: 4] <= ctl.path_waiting_clear_flag;
					prdata[sclid_pkg::STAT_SLEEP_BIT] <= ctl.sleep_active_flag;
				end
				default: begin
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================================================
	// Level bits of the control word
	// ==========================================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{ctl.event_history_freeze, ctl.sleep_request, ctl.case_switch_enable} <=
				sclid_pkg::CTRL_RST;
		end else if (wr && paddr == sclid_pkg::REG_CTRL) begin
			ctl.case_switch_enable <= pwdata[sclid_pkg::CTRL_CASE_EN_BIT];
			ctl.sleep_request <= pwdata[sclid_pkg::CTRL_SLEEP_BIT];
			ctl.event_history_freeze <= pwdata[sclid_pkg::CTRL_FREEZE_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctl.case_selector <= sclid_pkg::SEL_RST;
		end else if (wr && paddr == sclid_pkg::REG_SEL) begin
			ctl.case_selector <= pwdata[7:0];
		end
	end

	// ==========================================================================
	// Pulse generators: 0-1-0 with an exact minimum high phase
	// ==========================================================================
	logic [6:0] pulse_lvl;

	assign ctl.path_interlock_clear = pulse_lvl[3:0];
	assign ctl.safety_function_restart = pulse_lvl[sclid_pkg::CH_RUN];
	assign ctl.soft_restart_request = pulse_lvl[sclid_pkg::CH_SOFT];
	assign ctl.full_restart_request = pulse_lvl[sclid_pkg::CH_FULL];

	genvar gi;
	generate
		for (gi = 0; gi < sclid_pkg::NUM_CH; gi++) begin : g_pg
			localparam logic [W-1:0] LEN = (gi < sclid_pkg::NUM_PATHS) ?
				W'(FIELD_MIN_CYC) : W'(CMD_MIN_CYC);
			logic [W-1:0] cnt_r;

			assign busy[gi] = pulse_lvl[gi];

			// A start while busy is dropped, so pulses never merge into a level
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					pulse_lvl[gi] <= 1'b0;
					cnt_r <= '0;
				end else if (pulse_lvl[gi]) begin
					cnt_r <= cnt_r + 1'b1;
					pulse_lvl[gi] <= (cnt_r != LEN);
				end else if (wr && paddr == sclid_pkg::REG_PULSE && pwdata[gi]) begin
					pulse_lvl[gi] <= 1'b1;
					cnt_r <= {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	endgenerate

endmodule

// File: test/sclid_asserts.sv
// Checker on the control word between the controller and device ends.
// Assumes one sys_clk for both ends and the synchronous active-low rst_n.
`timescale 1ns/1ps
module sclid_asserts #(
	parameter int FIELD_MIN_CYC = sclid_pkg::FIELD_MIN_CYC,
	parameter int CMD_MIN_CYC = sclid_pkg::CMD_MIN_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Controller to device
	input wire logic sleep_request,
	input wire logic [3:0] path_interlock_clear,
	input wire logic safety_function_restart,
	input wire logic soft_restart_request,
	input wire logic full_restart_request,
	// Device to controller
	input wire logic safety_running_flag,
	input wire logic application_error_flag,
	input wire logic [3:0] path_waiting_clear_flag,
	input wire logic sleep_active_flag
);
	// ==========================================================================
	// Helper logic
	// ==========================================================================
	logic [6:0] ch;
	logic [21:0] hi_cnt [7];

	// Channels in controller pulse order
	assign ch = {full_restart_request, soft_restart_request, safety_function_restart,
		path_interlock_clear};

	// High samples per channel; a low sample clears, so a count always starts fresh
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 7; i++) begin
			if (!rst_n || !ch[i]) begin
				hi_cnt[i] <= 22'h00_0000;
			end else begin
				hi_cnt[i] <= hi_cnt[i] + 22'h00_0001;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================================
	// Pulse lengths and path interlocks
	// ==========================================================================
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_ch
			localparam int LEN = (g < 4) ? FIELD_MIN_CYC : CMD_MIN_CYC;
			a_pulse_exact_len: assert property ($fell(ch[g]) |-> hi_cnt[g] == LEN)
				else $error("pulse high phase differs from the set length");
		end
		for (g = 0; g < 4; g++) begin : g_path
			a_path_clear_on: assert property (
				path_waiting_clear_flag[g] && ch[g] && hi_cnt[g] == FIELD_MIN_CYC - 1
				|=> !path_waiting_clear_flag[g])
				else $error("path interlock not cleared by a full pulse");
			a_path_fall_cause: assert property ($fell(path_waiting_clear_flag[g]) |->
				$past(ch[g]) && $past(hi_cnt[g]) == FIELD_MIN_CYC - 1)
				else $error("path interlock cleared without its own full pulse");
		end
	endgenerate

	// ==========================================================================
	// Sleep, run start and restarts
	// ==========================================================================
	a_sleep_follows: assert property ($past(rst_n) |->
		sleep_active_flag == $past(sleep_request))
		else $error("sleep flag does not follow the request");
	a_run_recover: assert property (
		$fell(safety_function_restart) && application_error_flag
		|-> ##2 safety_running_flag && !application_error_flag)
		else $error("run start did not leave the application error");
	a_run_no_dev_exit: assert property (
		$fell(safety_function_restart) && !application_error_flag && !safety_running_flag
		|-> ##2 !safety_running_flag)
		else $error("run start ended a device error");
	a_soft_restart: assert property ($fell(soft_restart_request) |->
		##1 !safety_running_flag && path_waiting_clear_flag == 4'hf ##1 safety_running_flag)
		else $error("soft restart sequence wrong");
	a_full_restart: assert property ($fell(full_restart_request) |->
		##1 !safety_running_flag && path_waiting_clear_flag == 4'hf
		##1 safety_running_flag && !application_error_flag)
		else $error("full restart sequence wrong");
	c_run_recover: cover property ($fell(safety_function_restart) && application_error_flag);
	c_full_restart: cover property ($fell(full_restart_request));
	c_path_clear: cover property ($fell(path_waiting_clear_flag[0]));
endmodule

// File: test/sclid_tb_top.sv
// Testbench: controller and device joined by the control interface over APB,
// plus a second device whose control word the bench drives to break pulse rules.
// Assumes the design package, interface and both end modules are compiled first.
`timescale 1ns/1ps
module sclid_tb_top;
	localparam int FMIN = 20;
	localparam int CMIN = 40;
	typedef struct packed {
		logic [2:0] ctl;
		logic pm;
		logic [7:0] sel;
		logic [4:0] cs;
		logic rej;
	} sclid_row_type;
	// ==========================================================================
	// Signals
	// ==========================================================================
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pair_mode = 1'b0;
	logic app_ev = 1'b0;
	logic dev_ev = 1'b0;
	logic app_ev_f = 1'b0;
	logic [3:0] field_int = 4'h0;
	logic [4:0] active_case;
	logic case_reject;
	logic [7:0] history_count;
	logic hist_wr;
	logic dev_rst;
	logic net_rst;
	logic sw_off;
	logic [6:0] watch;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int tests_run = 0;
	// Ordinary case selections: enable and sleep first, then selectors
	sclid_row_type rows [8] = '{
		{3'h1, 1'b1, 8'haa, 5'h01, 1'b0}, {3'h3, 1'b1, 8'h55, 5'h10, 1'b0},
		{3'h1, 1'b1, 8'h66, 5'h0b, 1'b0}, {3'h1, 1'b1, 8'h00, 5'h00, 1'b1},
		{3'h1, 1'b0, 8'h80, 5'h08, 1'b0}, {3'h1, 1'b0, 8'h01, 5'h01, 1'b0},
		{3'h2, 1'b0, 8'h04, 5'h01, 1'b0}, {3'h1, 1'b0, 8'h03, 5'h00, 1'b1}};

	sclid_ctrl_if ctl ();
	sclid_ctrl_if ctl_f ();
	assign watch = {ctl_f.application_error_flag, ctl.path_waiting_clear_flag,
		ctl.safety_running_flag, dev_rst};

	always #25 sys_clk = ~sys_clk;
	// ==========================================================================
	// Design and checker
	// ==========================================================================
	sclid_controller #(.FIELD_MIN_CYC(FMIN), .CMD_MIN_CYC(CMIN)) u_sclid_controller (
		.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ctl(ctl));
	sclid_device #(.FIELD_MIN_CYC(FMIN), .CMD_MIN_CYC(CMIN)) u_sclid_device (
		.sys_clk(sys_clk), .rst_n(rst_n), .ctl(ctl), .pair_mode(pair_mode),
		.app_error_event(app_ev), .dev_error_event(dev_ev), .field_interrupt(field_int),
		.active_case(active_case), .case_reject(case_reject), .history_count(history_count),
		.history_write(hist_wr), .device_restart(dev_rst), .net_stack_restart(net_rst),
		.switch_forward_off(sw_off));
	sclid_device #(.FIELD_MIN_CYC(FMIN), .CMD_MIN_CYC(CMIN)) u_sclid_device_f (
		.sys_clk(sys_clk), .rst_n(rst_n), .ctl(ctl_f), .pair_mode(1'b0),
		.app_error_event(app_ev_f), .dev_error_event(1'b0), .field_interrupt(4'h0),
		.active_case(), .case_reject(), .history_count(), .history_write(),
		.device_restart(), .net_stack_restart(), .switch_forward_off());
	sclid_asserts #(.FIELD_MIN_CYC(FMIN), .CMD_MIN_CYC(CMIN)) u_sclid_asserts (
		.sys_clk(sys_clk), .rst_n(rst_n), .sleep_request(ctl.sleep_request),
		.path_interlock_clear(ctl.path_interlock_clear),
		.safety_function_restart(ctl.safety_function_restart),
		.soft_restart_request(ctl.soft_restart_request),
		.full_restart_request(ctl.full_restart_request),
		.safety_running_flag(ctl.safety_running_flag),
		.application_error_flag(ctl.application_error_flag),
		.path_waiting_clear_flag(ctl.path_waiting_clear_flag),
		.sleep_active_flag(ctl.sleep_active_flag));

	// ==========================================================================
	// Tasks
	// ==========================================================================
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_up(input logic ok);
		if (!ok) begin
			num_errors++;
			$display("mismatch at %0t: wait timed out", $time);
			stop_test();
		end
	endtask

	// One APB transfer; read data and error taken at the edge that sees pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		give_up(pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bounded wait for one watched status line to reach a level
	task automatic wait_for(input int i, input logic v);
		int n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (watch[i] !== v && n < 400);
		give_up(watch[i] === v);
	endtask

	// Fault device: channels 0..3 path clears, 4 run start
	task automatic drive_f(input int i, input logic v);
		if (i < 4) begin
			ctl_f.path_interlock_clear[i] <= v;
		end else begin
			ctl_f.safety_function_restart <= v;
		end
	endtask

	task automatic pulse_f(input int i, input int n);
		@(posedge sys_clk);
		drive_f(i, 1'b1);
		repeat (n) @(posedge sys_clk);
		drive_f(i, 1'b0);
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic one_cycle_event(input int k);
		@(posedge sys_clk);
		app_ev <= (k == 0);
		dev_ev <= (k == 1);
		app_ev_f <= (k == 2);
		@(posedge sys_clk);
		{app_ev, dev_ev, app_ev_f} <= 3'h0;
		repeat (2) @(posedge sys_clk);
	endtask

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		ctl_f.case_switch_enable = 1'b0;
		ctl_f.sleep_request = 1'b0;
		ctl_f.case_selector = 8'h00;
		ctl_f.event_history_freeze = 1'b0;
		ctl_f.path_interlock_clear = 4'h1;
		ctl_f.safety_function_restart = 1'b0;
		ctl_f.soft_restart_request = 1'b0;
		ctl_f.full_restart_request = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		apb(1'b0, sclid_pkg::REG_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_003d);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({err, rd[30:0]}, 32'h8000_0000);
		$display("reset and unmapped test done");
		// Fault device: level held through reset, short pulses, held run start
		repeat (2 * FMIN) @(posedge sys_clk);
		chk(32'(ctl_f.path_waiting_clear_flag), 32'h0000_000f);
		drive_f(0, 1'b0);
		pulse_f(1, FMIN - 1);
		chk(32'(ctl_f.path_waiting_clear_flag), 32'h0000_000f);
		one_cycle_event(2);
		pulse_f(4, CMIN - 1);
		chk(32'(ctl_f.application_error_flag), 32'h0000_0001);
		@(posedge sys_clk);
		drive_f(4, 1'b1);
		repeat (CMIN + 20) @(posedge sys_clk);
		chk(32'(ctl_f.application_error_flag), 32'h0000_0001);
		drive_f(4, 1'b0);
		wait_for(6, 1'b0);
		$display("rule breaking pulse test done");
		// Case selection rows; CTRL first so a disabled row cannot switch
		foreach (rows[i]) begin
			@(posedge sys_clk);
			pair_mode <= rows[i].pm;
			apb(1'b1, sclid_pkg::REG_CTRL, {29'h0000_0000, rows[i].ctl});
			apb(1'b1, sclid_pkg::REG_SEL, {24'h00_0000, rows[i].sel});
			repeat (2) @(posedge sys_clk);
			chk(32'(case_reject), 32'(rows[i].rej));
			if (!rows[i].rej) begin
				chk(32'(active_case), 32'(rows[i].cs));
			end
			apb(1'b0, sclid_pkg::REG_STATUS, 32'h0000_0000);
			chk(32'(rd[6]), 32'(rows[i].ctl[1]));
		end
		$display("case selection test done");
		// Two path clears together release only their own interlocks
		apb(1'b1, sclid_pkg::REG_PULSE, 32'h0000_0005);
		apb(1'b0, sclid_pkg::REG_PULSE, 32'h0000_0000);
		chk(rd, 32'h0000_0005);
		wait_for(2, 1'b0);
		chk(32'(ctl.path_waiting_clear_flag), 32'h0000_000a);
		@(posedge sys_clk);
		field_int <= 4'h3;
		@(posedge sys_clk);
		field_int <= 4'h0;
		@(posedge sys_clk);
		chk(32'(hist_wr), 32'h0000_0001);
		@(posedge sys_clk);
		chk(32'(history_count), 32'h0000_0002);
		chk(32'(ctl.path_waiting_clear_flag), 32'h0000_000b);
		apb(1'b1, sclid_pkg::REG_CTRL, 32'h0000_0004);
		@(posedge sys_clk);
		field_int <= 4'hf;
		@(posedge sys_clk);
		field_int <= 4'h0;
		repeat (2) @(posedge sys_clk);
		chk(32'(history_count), 32'h0000_0002);
		$display("path and history test done");
		// Run start leaves an application error but not a device error
		one_cycle_event(0);
		apb(1'b0, sclid_pkg::REG_STATUS, 32'h0000_0000);
		chk(32'(rd[1:0]), 32'h0000_0002);
		apb(1'b1, sclid_pkg::REG_PULSE, 32'h0000_0010);
		wait_for(1, 1'b1);
		chk(32'(ctl.application_error_flag), 32'h0000_0000);
		one_cycle_event(1);
		apb(1'b1, sclid_pkg::REG_PULSE, 32'h0000_0010);
		repeat (CMIN + 8) @(posedge sys_clk);
		chk(32'({ctl.safety_running_flag, ctl.application_error_flag}), 32'h0000_0000);
		// Soft restart keeps stack and switch; full restart takes both down
		apb(1'b1, sclid_pkg::REG_PULSE, 32'h0000_0021);
		wait_for(0, 1'b1);
		chk(32'({net_rst, sw_off}), 32'h0000_0000);
		wait_for(1, 1'b1);
		apb(1'b1, sclid_pkg::REG_PULSE, 32'h0000_0048);
		wait_for(0, 1'b1);
		chk(32'({net_rst, sw_off}), 32'h0000_0003);
		wait_for(1, 1'b1);
		chk(32'(ctl.path_waiting_clear_flag), 32'h0000_000f);
		$display("run start and restart test done");
		stop_test();
	end
endmodule
